/* design/ect_pkg.sv */
/*
  Package for the emulation event pin controller: state codes, the pin
  carrier type, counter width and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ect_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ECT_ST_IDLE  = 2'b00,
    ECT_ST_STOP  = 2'b01,
    ECT_ST_COUNT = 2'b10
  } ect_state_t;

  // ----------------------------------------------------------------
  // one two-way pin, output side; oe high while we drive it
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic oe;
    logic o;
  } ect_pin_t;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int         ECT_COUNT_W    = 16;
  localparam int         ECT_SYNC_W     = 2;
  localparam ect_pin_t   ECT_PIN_RELEASED = '{oe: 1'b0, o: 1'b0};
  localparam ect_state_t ECT_STATE_RST  = ECT_ST_IDLE;

endpackage

/* design/ect_event_pins.sv */
/*
  Emulation event pin controller of a target processor: drives the halt
  event pin and the count carry event pin, open-collector in signal-event
  mode and totem-pole in external count mode, and raises a halt request
  when an outside source pulls either pin low while not in external count mode.
  Assumes the pad ring combines *_oe/_o into the wire and returns the
  wire level on *_i; software controls arrive as same-clock levels/pulses.
*/
`timescale 1ns/100ps
module ect_event_pins
  import ect_pkg::*;
#(
  parameter int COUNT_W = ECT_COUNT_W
)
(
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // software controls
  input  wire logic     external_count_enable_i,
  input  wire logic     event_output_enable_i,
  input  wire logic     halt_on_event_enable_i,
  input  wire logic     signal_event_i,
  input  wire logic     stop_release_i,
  // processor status
  input  wire logic     count_tick_i,
  input  wire logic     processor_halted_i,
  // pins
  input  wire logic     halt_event_pin_i,
  output ect_pin_t      halt_event_pin_o,
  input  wire logic     count_carry_event_pin_i,
  output ect_pin_t      count_carry_event_pin_o,
  // to the processor
  output logic          halt_request_o,
  output logic          stop_signalled_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic       line_low_prev;
  logic       line_low;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // both lines idle high, so no false low edge follows reset
      sync_a <= 2'h3;
      sync_b <= 2'h3;
    end
    else
    begin
      sync_a <= {count_carry_event_pin_i, halt_event_pin_i};
      sync_b <= sync_a;
    end
  end

  assign line_low = ~sync_b[0] | ~sync_b[1];

  // ----------------------------------------------------------------
  // state, counter and pin drive
  // ----------------------------------------------------------------
  ect_state_t         state;
  ect_state_t         next_state;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic               next_carry;
  ect_pin_t           next_halt_pin;
  ect_pin_t           next_carry_pin;
  logic               next_halt_request;
  logic               next_line_low_prev;
  logic [1:0]         settle;
  logic [1:0]         next_settle;
  logic               next_stop_signalled;

  always_comb
  begin
    next_state         = state;
    next_count         = count;
    next_carry         = 1'b0;
    next_halt_pin      = ECT_PIN_RELEASED;
    next_carry_pin     = ECT_PIN_RELEASED;
    next_line_low_prev = line_low;
    next_halt_request  = 1'b0;
    next_settle        = settle;

    case (state)
      ECT_ST_IDLE:
      begin
        if (signal_event_i && event_output_enable_i)
          next_state = ECT_ST_STOP;
      end
      ECT_ST_STOP:
      begin
        // a new event in the release cycle keeps the pin low
        if (stop_release_i && !signal_event_i)
          next_state = ECT_ST_IDLE;
      end
      ECT_ST_COUNT:
      begin
        if (!external_count_enable_i)
          next_state = ECT_ST_IDLE;
      end
      default:
        next_state = ECT_ST_IDLE;
    endcase
    if (external_count_enable_i)
      next_state = ECT_ST_COUNT;

    if (next_state == ECT_ST_COUNT)
    begin
      if (count_tick_i)
      begin
        next_count = count + 1'b1;
        next_carry = &count;
      end
      next_halt_pin  = '{oe: 1'b1, o: processor_halted_i};
      next_carry_pin = '{oe: 1'b1, o: next_carry};
    end
    else if (next_state == ECT_ST_STOP)
    begin
      // open-collector: only ever pull low
      next_halt_pin  = '{oe: 1'b1, o: 1'b0};
      next_carry_pin = '{oe: 1'b1, o: 1'b0};
    end

    // own totem-pole levels linger in the synchroniser after count ends
    if (state == ECT_ST_COUNT)
      next_settle = 2'(ECT_SYNC_W);
    else if (settle != 2'h0)
      next_settle = settle - 2'h1;

    // own totem-pole drive is not an outside source, so count mode is excluded
    if (halt_on_event_enable_i && state != ECT_ST_COUNT && settle == 2'h0 && line_low && !line_low_prev)
      next_halt_request = 1'b1;

    next_stop_signalled = (next_state == ECT_ST_STOP);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state                   <= ECT_STATE_RST;
      count                   <= '0;
      halt_event_pin_o        <= ECT_PIN_RELEASED;
      count_carry_event_pin_o <= ECT_PIN_RELEASED;
      halt_request_o          <= 1'b0;
      stop_signalled_o        <= 1'b0;
      line_low_prev           <= 1'b0;
      settle                  <= 2'h0;
    end
    else
    begin
      state                   <= next_state;
      count                   <= next_count;
      halt_event_pin_o        <= next_halt_pin;
      count_carry_event_pin_o <= next_carry_pin;
      halt_request_o          <= next_halt_request;
      stop_signalled_o        <= next_stop_signalled;
      line_low_prev           <= next_line_low_prev;
      settle                  <= next_settle;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_count_drives_both;
    external_count_enable_i |=> halt_event_pin_o.oe && count_carry_event_pin_o.oe;
  endproperty
  a_count_drives_both: assert property (p_count_drives_both) else $error("count mode pins not driven");

  property p_carry_out;
    external_count_enable_i && count_tick_i && (&count) |=> count_carry_event_pin_o.o;
  endproperty
  a_carry_out: assert property (p_carry_out) else $error("carry not shown on pin");

  property p_no_false_carry;
    external_count_enable_i && !(count_tick_i && (&count)) |=> !count_carry_event_pin_o.o;
  endproperty
  a_no_false_carry: assert property (p_no_false_carry) else $error("carry pin high without wrap");

  property p_halted_shown;
    external_count_enable_i |=> halt_event_pin_o.o == $past(processor_halted_i);
  endproperty
  a_halted_shown: assert property (p_halted_shown) else $error("halt pin does not follow halted");

  sequence s_outside_low;
    halt_on_event_enable_i && state != ECT_ST_COUNT && !line_low ##1
    halt_on_event_enable_i && state != ECT_ST_COUNT && settle == 2'h0 && line_low;
  endsequence
  property p_halt_request;
    s_outside_low |=> halt_request_o ##1 !halt_request_o;
  endproperty
  a_halt_request: assert property (p_halt_request) else $error("outside low gave no single halt pulse");

  property p_no_halt_in_count;
    $past(state == ECT_ST_COUNT) |-> !halt_request_o;
  endproperty
  a_no_halt_in_count: assert property (p_no_halt_in_count) else $error("halt request during count");

  property p_no_halt_after_count;
    settle != 2'h0 |=> !halt_request_o;
  endproperty
  a_no_halt_after_count: assert property (p_no_halt_after_count) else $error("halt request from count levels");

  sequence s_stop_held;
    state == ECT_ST_STOP && !stop_release_i && !external_count_enable_i;
  endsequence
  property p_stop_held;
    s_stop_held |=> halt_event_pin_o.oe && !halt_event_pin_o.o && stop_signalled_o;
  endproperty
  a_stop_held: assert property (p_stop_held) else $error("stop pin released without software");

  property p_release;
    state == ECT_ST_STOP && stop_release_i && !signal_event_i && !external_count_enable_i
      |=> !halt_event_pin_o.oe && !count_carry_event_pin_o.oe;
  endproperty
  a_release: assert property (p_release) else $error("software release ignored");

endmodule

/* dv/ect_far_side.sv */
/*
  Far side of the event pins: pull-up wires, one open-collector outside
  source per pin, and the board cross-trigger logic that pulses the
  stop-input line once for each low on the bused stop-output line while no device counts.
  Assumes the bench says when any device on the lines is counting, and
  that the board clock doubles as the scan test clock.
*/
`timescale 1ns/100ps
module ect_far_side
  import ect_pkg::*;
#(
  parameter int PULSE_W   = 10,
  parameter int PULSE_LEN = 4
)
(
  // board clock and controller event-3 pin
  input  wire logic       clk_i,
  input  wire logic       controller_event3_pin_i,
  // from the device
  input  wire ect_pin_t   halt_pin_i,
  input  wire ect_pin_t   carry_pin_i,
  // outside source control; count_mode_i also holds the cross-trigger off
  input  wire logic [1:0] outside_low_i,
  input  wire logic       count_mode_i,
  // wire levels and cross-trigger output
  output logic            halt_wire_o,
  output logic            carry_wire_o,
  output logic            stop_input_line_o
);
  logic [1:0]         src_low;
  logic               test_reset_n;
  logic               stop_output_line;
  logic [1:0]         out_sync;
  logic               armed;
  logic [PULSE_W-1:0] pulse_cnt;

  // outside source kept quiet while anyone counts
  assign src_low = count_mode_i ? 2'h0 : outside_low_i;
  // pull-up when released, open-collector sources only pull low
  // the controller senses these wires on its event inputs 0 and 1
  assign halt_wire_o  = (halt_pin_i.oe ? halt_pin_i.o : 1'h1) & ~src_low[0];
  assign carry_wire_o = (carry_pin_i.oe ? carry_pin_i.o : 1'h1) & ~src_low[1];

  // ----------------------------------------------------------------
  // board cross-trigger logic
  // ----------------------------------------------------------------
  // test reset is the inverted controller event-3 output
  assign test_reset_n     = ~controller_event3_pin_i;
  // bused stop-output line is low while either event line is low
  assign stop_output_line = halt_wire_o & carry_wire_o;

  always_ff @(posedge clk_i or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      out_sync  <= 2'h3;
      armed     <= 1'b1;
      pulse_cnt <= '0;
    end
    else
    begin
      out_sync <= {out_sync[0], stop_output_line};
      // one pulse per low; rearm only once the line is seen high again
      armed    <= out_sync[1] & ~count_mode_i;
      if (count_mode_i)
        pulse_cnt <= '0;
      else if (armed && !out_sync[1])
        pulse_cnt <= PULSE_W'(PULSE_LEN);
      else if (pulse_cnt != '0)
        pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  // 4 cycles: over one scan clock, far under 10 us at 100 MHz
  assign stop_input_line_o = (pulse_cnt == '0) | count_mode_i;
endmodule

/* dv/ect_event_pins_tb.sv */
/*
  Self-checking bench for the event pin controller: notes of expected
  halt requests and carry pulses go into a queue; a watcher takes them.
  Assumes the far-side model in ect_far_side.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: mismatch", $time); end end
module ect_event_pins_tb
  import ect_pkg::*;
;
  logic clk_i = 0, rst_i = 1, xc = 0, evt_en = 0, hoe = 0, sig = 0, rel = 0, tick = 0, ph = 0;
  logic hw, cw, hreq, stopd;
  logic stop_in;
  int stop_len = 0, n_pulse = 0;
  logic [1:0] ext_low = 2'h0, cnt = 2'h0;
  ect_pin_t hp, cp;
  int n_mismatch = 0, checks = 0, seed = 74;
  logic [1:0] q[$];
  logic [1:0] note;

  always #5 clk_i = ~clk_i;

  ect_event_pins #(.COUNT_W(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .external_count_enable_i(xc),
    .event_output_enable_i(evt_en), .halt_on_event_enable_i(hoe), .signal_event_i(sig),
    .stop_release_i(rel), .count_tick_i(tick), .processor_halted_i(ph), .halt_event_pin_i(hw),
    .halt_event_pin_o(hp), .count_carry_event_pin_i(cw), .count_carry_event_pin_o(cp),
    .halt_request_o(hreq), .stop_signalled_o(stopd));

  ect_far_side far (.clk_i(clk_i), .controller_event3_pin_i(rst_i), .halt_pin_i(hp), .carry_pin_i(cp),
    .outside_low_i(ext_low), .count_mode_i(xc), .halt_wire_o(hw), .carry_wire_o(cw), .stop_input_line_o(stop_in));

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic take(logic [1:0] code);
    if (q.size() == 0)
    begin
      n_mismatch++;
      $display("Error %0t: unexpected result", $time);
    end
    else
    begin
      note = q.pop_front();
      `CHK(note, code)
    end
  endtask

  // ----------------------------------------------------------------
  // watcher: 1 = halt request, 2 = carry pulse
  // ----------------------------------------------------------------
  always @(negedge clk_i)
    if (!rst_i)
    begin
      if (hreq === 1'h1) take(2'h1);
      if (cp.oe === 1'h1 && cp.o === 1'h1) take(2'h2);
    end

  // ----------------------------------------------------------------
  // cross-trigger stop line: pulse width and count-mode hold
  // ----------------------------------------------------------------
  always @(negedge clk_i)
    if (!rst_i)
    begin
      if (xc)
        `CHK(stop_in, 1'h1)
      if (stop_in === 1'h0)
        stop_len++;
      else if (stop_len != 0)
      begin
        n_pulse++;
        `CHK(stop_len > 1 && stop_len < 1000, 1'h1)
        stop_len = 0;
      end
    end

  task automatic wait_empty();
    for (int i = 0; i < 10 && q.size() != 0; i++) step();
    if (q.size() != 0)
    begin
      n_mismatch++;
      $display("Error %0t: result missing", $time);
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    step(2);
    rst_i = 0;
    `CHK(hp, ECT_PIN_RELEASED)
    // stop from a signalled event; own low also raises a halt
    evt_en = 1; hoe = 1; sig = 1; rel = 1;
    step();
    sig = 0; rel = 0;
    q.push_back(2'h1);
    `CHK(hp, ect_pin_t'(2'h2))
    step(3);
    `CHK(stopd, 1'h1)
    // release and a new event together: set wins, pins stay low
    rel = 1; sig = 1;
    step();
    sig = 0;
    `CHK(stopd, 1'h1)
    step();
    rel = 0;
    `CHK(stopd, 1'h0)
    `CHK(cp, ECT_PIN_RELEASED)
    wait_empty();
    // outside low ignored while disabled, one pulse once enabled
    hoe = 0;
    // let the released lines reach the synchroniser so the low is a fresh edge
    step(3);
    ext_low = 2'h1;
    step(5);
    ext_low = 2'h0;
    step(3);
    hoe = 1; ext_low = 2'h2;
    q.push_back(2'h1);
    step(6);
    ext_low = 2'h0;
    wait_empty();
    // count mode: totem-pole pins, halted status and ripple carry
    xc = 1;
    for (int i = 0; i < 24; i++)
    begin
      step();
      `CHK(hp, ect_pin_t'({1'h1, ph}))
      `CHK(cp.oe, 1'h1)
      if (tick && cnt == 2'h3) q.push_back(2'h2);
      cnt = cnt + tick;
      ph = 1'($random(seed));
      tick = 1'($random(seed));
    end
    xc = 0; tick = 0;
    step(2);
    `CHK(hp, ECT_PIN_RELEASED)
    wait_empty();
    `CHK(n_pulse != 0, 1'h1)
    finish_test();
  end
endmodule
